// ===== hw/tspio_top.v
`timescale 1ns/10ps
`include "tspio_map.vh"
// Function
// - two-bit field picks secure clock source
// - bit3 enables D1 driver held low with serial host
// - three-bit field picks probe bit
// - reorder bit maps probe bus onto pins
// - prbs9 enabled, sends after transmit command
// - prbs15 enabled, sends after transmit command
// - five-bit field picks observed probe bus
// - bit7 zero disables uart aux lines
// - bits 6:0 enable matching pin drivers
// - enables only with serial; spi, or uart with aux lines on, D0-D4
// - io mode needs serial host interface
// - D1 never io while secure clock routed
// - io pin levels driven only when enabled; probe reorder sets levels on all seven pins
// - read pin value shows live pins while its bit7 is set
// - selected probe bus shown in status register
module tspio_top
#(
  parameter NUM_BUSES = 32
)
(
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire [5:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [1:0] host_if_kind,
  input wire osc_clk,
  input wire uart_clk,
  input wire rf_clk,
  output wire secure_clk,
  input wire [NUM_BUSES*8-1:0] probe_buses,
  output reg signal_out_pin,
  input wire [6:0] pin_in,
  output reg [6:0] pin_out,
  output reg [6:0] pin_oe,
  output wire uart_lines_on,
  input wire send_start,
  input wire tx_bit_adv,
  output wire prbs_sending,
  output wire prbs_bit
);
  // ==========================================================
  // registers
  reg [7:0] test_signal_select_reg;
  reg [7:0] probe_and_prbs_control_reg;
  reg [7:0] pin_driver_enable_reg;
  reg [7:0] pin_io_value_reg;
  reg [7:0] probe_stat;
  reg [7:0] pin_next;
  reg [6:0] oe_next;
  reg [6:0] lvl_next;
  reg [7:0] rd_next;
  reg [1:0] secure_clk_source;
  reg secure_clk_on_pin_d1;
  reg [2:0] probe_bit_pick;
  reg probe_bus_reorder;
  reg [4:0] probe_bus_pick;
  reg spare_pins_as_io;
  reg [6:0] pin_drive_enable;
  reg [6:0] spare_pin_level;
  reg secure_sel;
  wire serial_if;
  wire io_active;
  wire [6:0] usable_mask;
  integer i;

  function hit;
    input [5:0] a;
    input [5:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  always @*
  begin
    secure_clk_source = test_signal_select_reg[`TSPIO_SCLK_HI:`TSPIO_SCLK_LO];
    secure_clk_on_pin_d1 = test_signal_select_reg[`TSPIO_SCLK_D1_BIT];
    probe_bit_pick = test_signal_select_reg[`TSPIO_BITPICK_HI:`TSPIO_BITPICK_LO];
    probe_bus_reorder = probe_and_prbs_control_reg[`TSPIO_REORDER_BIT];
    probe_bus_pick = probe_and_prbs_control_reg[`TSPIO_BUSPICK_HI:`TSPIO_BUSPICK_LO];
    spare_pins_as_io = pin_io_value_reg[`TSPIO_USE_IO_BIT];
    pin_drive_enable = pin_driver_enable_reg[`TSPIO_PIN_HI:`TSPIO_PIN_LO];
    spare_pin_level = pin_io_value_reg[`TSPIO_PIN_HI:`TSPIO_PIN_LO];
  end

  // ==========================================================
  // host writes
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      test_signal_select_reg <= `TSPIO_RST_TEST_SEL;
      probe_and_prbs_control_reg <= `TSPIO_RST_PROBE_CTL;
      pin_driver_enable_reg <= `TSPIO_RST_PIN_EN;
      pin_io_value_reg <= `TSPIO_RST_PIN_VAL;
    end
    else if (clk_en && reg_wr)
    begin
      if (hit(reg_addr, `TSPIO_OFS_TEST_SEL))
        test_signal_select_reg <= reg_wdata;
      if (hit(reg_addr, `TSPIO_OFS_PROBE_CTL))
        probe_and_prbs_control_reg <= reg_wdata;
      if (hit(reg_addr, `TSPIO_OFS_PIN_EN))
        pin_driver_enable_reg <= reg_wdata;
      if (hit(reg_addr, `TSPIO_OFS_PIN_VAL))
        pin_io_value_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // secure clock source
  always @*
  begin
    case (secure_clk_source)
      `TSPIO_SCLK_OFF: secure_sel = 1'b0;
      `TSPIO_SCLK_OSC: secure_sel = osc_clk;
      `TSPIO_SCLK_UART: secure_sel = uart_clk;
      `TSPIO_SCLK_RF: secure_sel = rf_clk;
      default: secure_sel = 1'b0;
    endcase
  end
  assign secure_clk = secure_sel;
  assign uart_lines_on = pin_driver_enable_reg[`TSPIO_UART_LINES_BIT];

  // ==========================================================
  // pin control
  assign serial_if = (host_if_kind != `TSPIO_HIF_PAR);
  assign usable_mask = ((host_if_kind == `TSPIO_HIF_SPI) ||
                        ((host_if_kind == `TSPIO_HIF_UART) && uart_lines_on)) ?
                       `TSPIO_SERIAL_PINS_MASK : `TSPIO_ALL_PINS_MASK;
  assign io_active = spare_pins_as_io && serial_if;

  always @*
  begin
    probe_stat = probe_buses[probe_bus_pick*8 +: 8];
    oe_next = 7'h00;
    lvl_next = 7'h00;
    if (probe_bus_reorder && !io_active)
    begin
      // probe bus bits 6..0 onto D4,D3,D2,D6,D5,D0,D1
      lvl_next[4] = probe_stat[6];
      lvl_next[3] = probe_stat[5];
      lvl_next[2] = probe_stat[4];
      lvl_next[6] = probe_stat[3];
      lvl_next[5] = probe_stat[2];
      lvl_next[0] = probe_stat[1];
      lvl_next[1] = probe_stat[0];
      oe_next = usable_mask;
    end
    else if (io_active)
    begin
      oe_next = pin_drive_enable & usable_mask;
      lvl_next = spare_pin_level & oe_next;
    end
    if (secure_clk_on_pin_d1 && serial_if)
    begin
      oe_next[`TSPIO_D1] = 1'b1;
      lvl_next[`TSPIO_D1] = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out <= 7'h00;
      pin_oe <= 7'h00;
      signal_out_pin <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_out <= lvl_next;
      pin_oe <= oe_next;
      signal_out_pin <= probe_stat[probe_bit_pick];
    end
  end

  // ==========================================================
  // read data
  always @*
  begin
    pin_next = pin_io_value_reg;
    if (spare_pins_as_io)
    begin
      for (i = 0; i < 7; i = i + 1)
        pin_next[i] = pin_in[i];
    end
    rd_next = 8'h00;
    case (reg_addr)
      `TSPIO_OFS_TEST_SEL: rd_next = test_signal_select_reg;
      `TSPIO_OFS_PROBE_CTL: rd_next = probe_and_prbs_control_reg;
      `TSPIO_OFS_PIN_EN: rd_next = pin_driver_enable_reg;
      `TSPIO_OFS_PIN_VAL: rd_next = pin_next;
      `TSPIO_OFS_PROBE_STAT: rd_next = probe_stat;
      default: rd_next = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
      reg_rdata <= rd_next;
  end

  // ==========================================================
  // prbs generator
  tspio_prbs u_prbs
  (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .prbs9_on(probe_and_prbs_control_reg[`TSPIO_PRBS9_BIT]),
    .prbs15_on(probe_and_prbs_control_reg[`TSPIO_PRBS15_BIT]),
    .send_start(send_start),
    .bit_adv(tx_bit_adv),
    .sending(prbs_sending),
    .prbs_bit(prbs_bit)
  );
endmodule

// ===== hw/tspio_map.vh
`ifndef TSPIO_MAP_VH
`define TSPIO_MAP_VH
// ==========================================================
// register offsets
`define TSPIO_OFS_TEST_SEL 6'h31
`define TSPIO_OFS_PROBE_CTL 6'h32
`define TSPIO_OFS_PIN_EN 6'h33
`define TSPIO_OFS_PIN_VAL 6'h34
`define TSPIO_OFS_PROBE_STAT 6'h35
// ==========================================================
// reset values
`define TSPIO_RST_TEST_SEL 8'h00
`define TSPIO_RST_PROBE_CTL 8'h00
`define TSPIO_RST_PIN_EN 8'h80
`define TSPIO_RST_PIN_VAL 8'h00
// ==========================================================
// field positions
`define TSPIO_SCLK_HI 5
`define TSPIO_SCLK_LO 4
`define TSPIO_SCLK_D1_BIT 3
`define TSPIO_BITPICK_HI 2
`define TSPIO_BITPICK_LO 0
`define TSPIO_REORDER_BIT 7
`define TSPIO_PRBS9_BIT 6
`define TSPIO_PRBS15_BIT 5
`define TSPIO_BUSPICK_HI 4
`define TSPIO_BUSPICK_LO 0
`define TSPIO_UART_LINES_BIT 7
`define TSPIO_USE_IO_BIT 7
`define TSPIO_PIN_HI 6
`define TSPIO_PIN_LO 0
// ==========================================================
// secure clock source codes
`define TSPIO_SCLK_OFF 2'h0
`define TSPIO_SCLK_OSC 2'h1
`define TSPIO_SCLK_UART 2'h2
`define TSPIO_SCLK_RF 2'h3
// ==========================================================
// host interface kinds
`define TSPIO_HIF_PAR 2'h0
`define TSPIO_HIF_SPI 2'h1
`define TSPIO_HIF_UART 2'h2
`define TSPIO_HIF_I2C 2'h3
// ==========================================================
// prbs seeds and pin constants
`define TSPIO_PRBS9_SEED 9'h1ff
`define TSPIO_PRBS15_SEED 15'h7fff
`define TSPIO_SERIAL_PINS_MASK 7'h1f
`define TSPIO_ALL_PINS_MASK 7'h7f
`define TSPIO_D1 1
`endif

// ===== hw/tspio_prbs.v
`timescale 1ns/10ps
`include "tspio_map.vh"
// ==========================================================
// prbs9 / prbs15 generator
module tspio_prbs
(
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire prbs9_on,
  input wire prbs15_on,
  input wire send_start,
  input wire bit_adv,
  output reg sending,
  output reg prbs_bit
);
  reg [8:0] p9_reg;
  reg [14:0] p15_reg;
  wire use9;
  wire fb9;
  wire fb15;
  assign use9 = prbs9_on;
  assign fb9 = p9_reg[8] ^ p9_reg[4];
  assign fb15 = p15_reg[14] ^ p15_reg[13];

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      p9_reg <= `TSPIO_PRBS9_SEED;
      p15_reg <= `TSPIO_PRBS15_SEED;
      sending <= 1'b0;
      prbs_bit <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!prbs9_on && !prbs15_on)
      begin
        sending <= 1'b0;
        prbs_bit <= 1'b0;
        p9_reg <= `TSPIO_PRBS9_SEED;
        p15_reg <= `TSPIO_PRBS15_SEED;
      end
      else if (!sending)
      begin
        sending <= send_start;
      end
      else if (bit_adv)
      begin
        if (use9)
        begin
          p9_reg <= {p9_reg[7:0], fb9};
          prbs_bit <= p9_reg[8];
        end
        else
        begin
          p15_reg <= {p15_reg[13:0], fb15};
          prbs_bit <= p15_reg[14];
        end
      end
    end
  end
endmodule

// ===== bench/tspio_pins_model.sv
`timescale 1ns/10ps
// ==========================================
// external circuitry on the spare pins
module tspio_pins_model
(
  input wire [6:0] pin_out,
  input wire [6:0] pin_oe,
  input wire [6:0] ext_val,
  output logic [6:0] pin_in,
  output logic osc_clk,
  output logic uart_clk,
  output logic rf_clk
);
  // outside world drives only released pins
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
  initial
  begin
    osc_clk = 1'b0;
    forever #37 osc_clk = ~osc_clk;
  end
  initial
  begin
    uart_clk = 1'b0;
    forever #21 uart_clk = ~uart_clk;
  end
  initial
  begin
    rf_clk = 1'b0;
    forever #29 rf_clk = ~rf_clk;
  end
endmodule

// ===== bench/tspio_properties.sv
`timescale 1ns/10ps
// ==========================================
// port checks
module tspio_props #(parameter NUM_BUSES = 32)
(
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire [5:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [1:0] host_if_kind,
  input wire [NUM_BUSES*8-1:0] probe_buses,
  input wire signal_out_pin,
  input wire [6:0] pin_out,
  input wire [6:0] pin_oe,
  input wire uart_lines_on,
  input wire send_start,
  input wire prbs_sending
);
  reg [7:0] sel, ctl, en, val;
  wire io = val[7] && host_if_kind != 2'h0 && !sel[3];
  wire ser5 = host_if_kind == 2'h1 || (host_if_kind == 2'h2 && en[7]);
  wire [6:0] msk = ser5 ? 7'h1f : 7'h7f;
  wire [7:0] pb = probe_buses[ctl[4:0]*8 +: 8];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // shadow of the writable registers
  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      sel <= 8'h00;
      ctl <= 8'h00;
      en <= 8'h80;
      val <= 8'h00;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == 6'h31) sel <= reg_wdata;
      if (reg_addr == 6'h32) ctl <= reg_wdata;
      if (reg_addr == 6'h33) en <= reg_wdata;
      if (reg_addr == 6'h34) val <= reg_wdata;
    end
  uart_lines_a: assert property (uart_lines_on == en[7])
    else $error("uart lines wrong");
  io_oe_a: assert property (clk_en && io |=> pin_oe == $past(en[6:0] & msk))
    else $error("pin enables wrong");
  io_out_a: assert property (clk_en && io |=> (pin_out & pin_oe) == ($past(val[6:0]) & pin_oe))
    else $error("pin levels wrong");
  d1_clock_a: assert property (clk_en && sel[3] && host_if_kind != 2'h0 |=> pin_oe[1] && !pin_out[1])
    else $error("d1 not clock");
  par_off_a: assert property (clk_en && host_if_kind == 2'h0 && !ctl[7] |=> pin_oe == 7'h00)
    else $error("parallel pins driven");
  probe_bit_a: assert property (clk_en |=> signal_out_pin == $past(pb[sel[2:0]]))
    else $error("probe bit wrong");
  prbs_go_a: assert property (clk_en && send_start && (ctl[6] || ctl[5]) |=> prbs_sending)
    else $error("prbs not started");
  prbs_wait_a: assert property ($rose(prbs_sending) |-> $past(send_start))
    else $error("prbs without command");
endmodule
bind tspio_top tspio_props #(.NUM_BUSES(NUM_BUSES)) chk (.*);

// ===== bench/test_signal_and_spare_pin_io_tb.sv
`timescale 1ns/10ps
// ==========================================
// testbench
module test_signal_and_spare_pin_io_tb;
  logic clk = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic send_start = 0, tx_bit_adv = 0, osc_clk, uart_clk, rf_clk;
  logic secure_clk, signal_out_pin, uart_lines_on, prbs_sending, prbs_bit;
  logic [5:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, d, pb;
  logic [1:0] host_if_kind = 2'h1;
  logic [255:0] probe_buses;
  logic [6:0] pin_in, pin_out, pin_oe, ext_val = 7'h54;
  logic [63:0] bs;
  int miscompares = 0, n_tests = 0;
  tspio_top #(.NUM_BUSES(32)) uut (.*);
  tspio_pins_model pins (.*);
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", w, e, s);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic st;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic kind(input logic [1:0] k);
    @(posedge clk);
    host_if_kind <= k;
  endtask
  task automatic test_done;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      rd(6'h31 + i);
      chk("reset", d, (i == 2) ? 8'h80 : 8'h00);
    end
    rd(6'h3f);
    chk("unmapped", d, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(6'h31, c << 4);
      st;
      chk("sclk", secure_clk, c == 0 ? 0 : c == 1 ? osc_clk : c == 2 ? uart_clk : rf_clk);
    end
    @(posedge clk);
    clk_en <= 0;
    wr(6'h31, 8'h07);
    clk_en <= 1;
    rd(6'h31);
    chk("frozen", d, 8'h30);
    $display("registers done");
  endtask
  task automatic t_io;
    wr(6'h31, 8'h00);
    wr(6'h34, 8'h83);
    wr(6'h33, 8'hff);
    st;
    chk("spi oe", pin_oe, 8'h1f);
    chk("spi out", pin_out & pin_oe, 8'h03);
    kind(2'h2);
    wr(6'h33, 8'h01);
    st;
    chk("uart oe", pin_oe, 8'h01);
    rd(6'h34);
    chk("live", d[6:0], 8'h55);
    wr(6'h31, 8'h08);
    st;
    chk("d1", {pin_oe[1], pin_out[1]}, 8'h02);
    kind(2'h0);
    st;
    chk("par oe", pin_oe, 8'h00);
    $display("pins done");
  endtask
  task automatic t_probe;
    kind(2'h2);
    wr(6'h34, 8'h00);
    wr(6'h33, 8'h00);
    wr(6'h32, 8'h85);
    pb = probe_buses[47:40];
    for (int b = 0; b < 8; b++)
    begin
      wr(6'h31, b);
      st;
      chk("signal_out_pin", signal_out_pin, pb[b]);
    end
    chk("reorder", pin_out, {pb[3], pb[2], pb[6:4], pb[0], pb[1]});
    rd(6'h35);
    chk("status", d, pb);
    $display("probe done");
  endtask
  task automatic t_prbs(input logic [7:0] m, input int n, input int t);
    int e = 0;
    wr(6'h32, m);
    st;
    chk("idle", prbs_sending, 0);
    @(posedge clk);
    send_start <= 1;
    @(posedge clk);
    send_start <= 0;
    for (int i = 0; i < 5 && prbs_sending !== 1'b1; i++) @(posedge clk);
    chk("sending", prbs_sending, 1);
    tx_bit_adv <= 1;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clk);
      #1 bs[i] = prbs_bit;
    end
    tx_bit_adv <= 0;
    for (int i = 0; i + n < 64; i++) e += (bs[i + n] !== (bs[i + t] ^ bs[i]));
    chk("prbs", e, 0);
    chk("seed", bs[0], 1);
    wr(6'h32, 8'h00);
    st;
    chk("stop", prbs_sending, 0);
    $display("prbs done");
  endtask
  initial
  begin
    for (int k = 0; k < 32; k++) probe_buses[k*8 +: 8] = 8'h11 + k * 8'h25;
    repeat (12) @(posedge clk);
    resetn <= 1;
    t_regs;
    t_io;
    t_probe;
    t_prbs(8'h60, 9, 4);
    t_prbs(8'h20, 15, 1);
    test_done;
  end
  initial
  begin
    #500us;
    miscompares++;
    test_done;
  end
endmodule
